// ===== design/msc_pin_if.sv
// synchronised sideband pin levels passed from the synchroniser to the core
// assumes both ends run on the same clock
interface msc_pin_if;
	logic select_n;
	logic reset_n;
	logic low_power;
	logic scl;
	logic sda;

	modport sync_side (
		output select_n,
		output reset_n,
		output low_power,
		output scl,
		output sda
	);

	modport core_side (
		input select_n,
		input reset_n,
		input low_power,
		input scl,
		input sda
	);
endinterface : msc_pin_if

// ===== design/msc_pin_sync.sv
// two-flop synchronisers for the asynchronous sideband and 2-wire pins
// assumes the pins are levels from the host with no relation to clock
module msc_pin_sync
	import msc_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic module_select_n_pin,
	input wire logic module_reset_n,
	input wire logic low_power_request,
	input wire logic scl_pin,
	input wire logic sda_in,
	msc_pin_if.sync_side pins
);
	logic [4:0] meta_q;
	logic [4:0] meta_d;
	logic [4:0] stable_q;
	logic [4:0] stable_d;

	always_comb begin
		meta_d = {sda_in, scl_pin, low_power_request, module_reset_n,
			module_select_n_pin};
		stable_d = meta_q;
	end

	// reset value deselects the module, as the idle pull-up would
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			meta_q <= MSC_SYNC_RESET;
			stable_q <= MSC_SYNC_RESET;
		end else begin
			meta_q <= meta_d;
			stable_q <= stable_d;
		end
	end

	assign pins.select_n = stable_q[0];
	assign pins.reset_n = stable_q[1];
	assign pins.low_power = stable_q[2];
	assign pins.scl = stable_q[3];
	assign pins.sda = stable_q[4];
endmodule : msc_pin_sync

// ===== design/msc_pkg.sv
// constants, register map and state codes of the module sideband control
// assumes a single 50 MHz clock and a synchronous active-low system reset
package msc_pkg;

	// clock
	localparam int unsigned MSC_CLK_HZ = 50_000_000;
	localparam int unsigned MSC_CLK_PERIOD_NS = 20;

	// least reset pulse on the reset pin, rounded up to whole cycles
	localparam int unsigned MSC_T_RESET_MIN_NS = 2;
	localparam int unsigned MSC_RESET_MIN_CYC =
		(MSC_T_RESET_MIN_NS * 1000 + MSC_CLK_PERIOD_NS - 1) /
		MSC_CLK_PERIOD_NS;
	localparam int MSC_RST_CNT_W = 8;

	// longest init and serial ready times in ms, rounded down to cycles
	localparam int unsigned MSC_T_INIT_MS = 2000;
	localparam int unsigned MSC_INIT_CYC =
		MSC_T_INIT_MS * (MSC_CLK_HZ / 1000);
	localparam int unsigned MSC_T_SERIAL_MS = 2000;
	localparam int unsigned MSC_SERIAL_CYC =
		MSC_T_SERIAL_MS * (MSC_CLK_HZ / 1000);
	localparam int MSC_INIT_CNT_W = 27;

	// register port
	localparam int MSC_ADDR_W = 4;
	localparam int MSC_DATA_W = 16;
	localparam logic [MSC_ADDR_W-1:0] MSC_ADDR_STATUS = 4'h0;
	localparam logic [MSC_ADDR_W-1:0] MSC_ADDR_MASK = 4'h1;
	localparam logic [MSC_ADDR_W-1:0] MSC_ADDR_CONTROL = 4'h2;
	localparam logic [MSC_ADDR_W-1:0] MSC_ADDR_STATE = 4'h3;

	// status and mask layout
	localparam int MSC_ST_RESET_DONE = 0;
	localparam int MSC_ST_ALARM_LSB = 1;
	localparam int MSC_ST_WARN_LSB = 5;
	localparam int MSC_CHANNELS = 4;
	localparam logic [MSC_DATA_W-1:0] MSC_STATUS_USED = 16'h01FF;
	localparam logic [MSC_DATA_W-1:0] MSC_STATUS_RESET = 16'h0000;
	localparam logic [MSC_DATA_W-1:0] MSC_MASK_RESET = 16'h01FF;

	// control layout
	localparam int MSC_CTL_FORCE_LP = 0;
	localparam logic [MSC_DATA_W-1:0] MSC_CONTROL_USED = 16'h0001;
	localparam logic [MSC_DATA_W-1:0] MSC_CONTROL_RESET = 16'h0000;

	// state register layout
	localparam int MSC_SR_NOT_READY = 0;
	localparam int MSC_SR_SELECTED = 1;
	localparam int MSC_SR_LOW_POWER = 2;
	localparam int MSC_SR_IN_RESET = 3;
	localparam int MSC_SR_BUS_READY = 4;

	// synchroniser reset: {sda, scl, low_power, reset_n, select_n}
	localparam logic [4:0] MSC_SYNC_RESET = 5'h1B;

	typedef enum logic [2:0] {
		MSC_ST_INIT = 3'b001,
		MSC_ST_RUN = 3'b010,
		MSC_ST_HOLD = 3'b100
	} msc_state_t;

endpackage : msc_pkg

// ===== design/msc_sideband.sv
// sideband control of a pluggable transceiver module: select gate on the
// 2-wire bus, reset filter and init window, low power, presence, interrupt
// assumes a 2-wire slave core beside it on the same clock and pads that
// resolve the open-drain outputs from their enables
module msc_sideband
	import msc_pkg::*;
#(
	parameter int unsigned INIT_CYCLES = MSC_INIT_CYC,
	parameter int unsigned SERIAL_CYCLES = MSC_SERIAL_CYC
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic module_select_n_pin,
	input wire logic module_reset_n,
	input wire logic low_power_request,
	input wire logic scl_pin,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	output logic select_pullup_en,
	output logic twi_enable,
	output logic twi_scl,
	output logic twi_sda,
	input wire logic twi_sda_drive_low,
	input wire logic [MSC_CHANNELS-1:0] chan_alarm,
	input wire logic [MSC_CHANNELS-1:0] chan_warn,
	output logic low_power_state,
	output logic settings_reset,
	output logic module_present_n,
	output logic module_interrupt_n_out,
	output logic module_interrupt_n_oe_n,
	input wire logic [MSC_ADDR_W-1:0] reg_addr,
	input wire logic [MSC_DATA_W-1:0] reg_wdata,
	input wire logic reg_we,
	input wire logic reg_re,
	output logic [MSC_DATA_W-1:0] reg_rdata
);

	function automatic logic [MSC_INIT_CNT_W-1:0] last_count(
		input int unsigned cycles
	);
		last_count = MSC_INIT_CNT_W'(cycles - 1);
	endfunction : last_count

	localparam logic [MSC_RST_CNT_W-1:0] RST_LAST =
		MSC_RST_CNT_W'(MSC_RESET_MIN_CYC - 1);

	msc_pin_if pins ();

	msc_pin_sync u_sync (
		.clock(clock),
		.rst_n(rst_n),
		.module_select_n_pin(module_select_n_pin),
		.module_reset_n(module_reset_n),
		.low_power_request(low_power_request),
		.scl_pin(scl_pin),
		.sda_in(sda_in),
		.pins(pins)
	);

	// sequencing state
	msc_state_t state_q;
	msc_state_t state_d;
	logic [MSC_INIT_CNT_W-1:0] init_cnt_q;
	logic [MSC_INIT_CNT_W-1:0] init_cnt_d;
	logic [MSC_RST_CNT_W-1:0] rst_cnt_q;
	logic [MSC_RST_CNT_W-1:0] rst_cnt_d;
	logic bus_ready_q;
	logic bus_ready_d;
	logic not_ready_q;
	logic not_ready_d;
	logic init_done;
	logic enter_hold;

	// registers
	logic [MSC_DATA_W-1:0] status_q;
	logic [MSC_DATA_W-1:0] status_d;
	logic [MSC_DATA_W-1:0] mask_q;
	logic [MSC_DATA_W-1:0] mask_d;
	logic [MSC_DATA_W-1:0] control_q;
	logic [MSC_DATA_W-1:0] control_d;
	logic [MSC_DATA_W-1:0] rdata_q;
	logic [MSC_DATA_W-1:0] rdata_d;
	logic [MSC_DATA_W-1:0] status_set;
	logic [MSC_DATA_W-1:0] status_clr;

	// pin side outputs
	logic sda_oe_n_q;
	logic sda_oe_n_d;
	logic twi_en_q;
	logic twi_en_d;
	logic twi_scl_q;
	logic twi_scl_d;
	logic twi_sda_q;
	logic twi_sda_d;
	logic lp_q;
	logic lp_d;
	logic irq_q;
	logic irq_d;
	logic hold_q;
	logic hold_d;

	logic selected;
	assign selected = ~pins.select_n;

	// sequencer: power-up init, reset filter, hold, init on release
	always_comb begin
		state_d = state_q;
		init_cnt_d = init_cnt_q;
		rst_cnt_d = rst_cnt_q;
		bus_ready_d = bus_ready_q;
		not_ready_d = not_ready_q;
		init_done = 1'b0;
		enter_hold = 1'b0;
		if (pins.reset_n || state_q == MSC_ST_HOLD) begin
			rst_cnt_d = '0;
		end else if (rst_cnt_q != RST_LAST) begin
			rst_cnt_d = rst_cnt_q + MSC_RST_CNT_W'(1);
		end
		case (state_q)
			MSC_ST_INIT: begin
				init_cnt_d = init_cnt_q + MSC_INIT_CNT_W'(1);
				if (init_cnt_q == last_count(SERIAL_CYCLES)) begin
					bus_ready_d = 1'b1;
				end
				if (init_cnt_q == last_count(INIT_CYCLES)) begin
					state_d = MSC_ST_RUN;
					init_cnt_d = '0;
					bus_ready_d = 1'b1;
					not_ready_d = 1'b0;
					init_done = 1'b1;
				end
			end
			MSC_ST_RUN: begin
				init_cnt_d = '0;
			end
			MSC_ST_HOLD: begin
				init_cnt_d = '0;
				if (pins.reset_n) begin
					state_d = MSC_ST_INIT;
				end
			end
			default: begin
				state_d = MSC_ST_INIT;
				init_cnt_d = '0;
			end
		endcase
		if (state_q != MSC_ST_HOLD && !pins.reset_n &&
				rst_cnt_q == RST_LAST) begin
			state_d = MSC_ST_HOLD;
			init_cnt_d = '0;
			not_ready_d = 1'b1;
			init_done = 1'b0;
			enter_hold = 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state_q <= MSC_ST_INIT;
			init_cnt_q <= '0;
			rst_cnt_q <= '0;
			bus_ready_q <= 1'b0;
			not_ready_q <= 1'b1;
		end else begin
			state_q <= state_d;
			init_cnt_q <= init_cnt_d;
			rst_cnt_q <= rst_cnt_d;
			bus_ready_q <= bus_ready_d;
			not_ready_q <= not_ready_d;
		end
	end

	// register file; a flag raised in the cycle of its read stays set
	always_comb begin
		status_set = '0;
		status_set[MSC_ST_RESET_DONE] = init_done;
		status_set[MSC_ST_ALARM_LSB +: MSC_CHANNELS] = chan_alarm;
		status_set[MSC_ST_WARN_LSB +: MSC_CHANNELS] = chan_warn;
		status_clr = '0;
		mask_d = mask_q;
		control_d = control_q;
		rdata_d = '0;
		if (reg_re) begin
			if (reg_addr == MSC_ADDR_STATUS) begin
				rdata_d = status_q;
				status_clr = MSC_STATUS_USED;
			end else if (reg_addr == MSC_ADDR_MASK) begin
				rdata_d = mask_q;
			end else if (reg_addr == MSC_ADDR_CONTROL) begin
				rdata_d = control_q;
			end else if (reg_addr == MSC_ADDR_STATE) begin
				rdata_d[MSC_SR_NOT_READY] = not_ready_q;
				rdata_d[MSC_SR_SELECTED] = selected;
				rdata_d[MSC_SR_LOW_POWER] = lp_q;
				rdata_d[MSC_SR_IN_RESET] = hold_q;
				rdata_d[MSC_SR_BUS_READY] = bus_ready_q;
			end
		end
		if (reg_we) begin
			if (reg_addr == MSC_ADDR_MASK) begin
				mask_d = reg_wdata & MSC_STATUS_USED;
			end else if (reg_addr == MSC_ADDR_CONTROL) begin
				control_d = reg_wdata & MSC_CONTROL_USED;
			end
		end
		status_d = ((status_q & ~status_clr) | status_set) &
			MSC_STATUS_USED;
		if (enter_hold || state_q == MSC_ST_HOLD) begin
			mask_d = MSC_MASK_RESET;
			control_d = MSC_CONTROL_RESET;
			status_d = MSC_STATUS_RESET;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			status_q <= MSC_STATUS_RESET;
			mask_q <= MSC_MASK_RESET;
			control_q <= MSC_CONTROL_RESET;
			rdata_q <= '0;
		end else begin
			status_q <= status_d;
			mask_q <= mask_d;
			control_q <= control_d;
			rdata_q <= rdata_d;
		end
	end

	// pin side: bus gate, low power, interrupt, hold indication
	always_comb begin
		twi_en_d = selected && bus_ready_q && state_q != MSC_ST_HOLD;
		twi_scl_d = twi_en_d ? pins.scl : 1'b1;
		twi_sda_d = twi_en_d ? pins.sda : 1'b1;
		sda_oe_n_d = ~(twi_en_d && twi_sda_drive_low);
		lp_d = pins.low_power || control_q[MSC_CTL_FORCE_LP];
		irq_d = |(status_q & mask_q);
		hold_d = state_d == MSC_ST_HOLD;
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			twi_en_q <= 1'b0;
			twi_scl_q <= 1'b1;
			twi_sda_q <= 1'b1;
			sda_oe_n_q <= 1'b1;
			lp_q <= 1'b0;
			irq_q <= 1'b0;
			hold_q <= 1'b0;
		end else begin
			twi_en_q <= twi_en_d;
			twi_scl_q <= twi_scl_d;
			twi_sda_q <= twi_sda_d;
			sda_oe_n_q <= sda_oe_n_d;
			lp_q <= lp_d;
			irq_q <= irq_d;
			hold_q <= hold_d;
		end
	end

	assign twi_enable = twi_en_q;
	assign twi_scl = twi_scl_q;
	assign twi_sda = twi_sda_q;
	// data output removed within one cycle of the enable dropping
	assign sda_oe_n = sda_oe_n_q | ~twi_en_q;
	assign sda_out = 1'b0;
	assign select_pullup_en = 1'b1;
	assign module_present_n = 1'b0;
	assign module_interrupt_n_out = 1'b0;
	assign module_interrupt_n_oe_n = ~irq_q;
	assign low_power_state = lp_q;
	assign settings_reset = hold_q;
	assign reg_rdata = rdata_q;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);
	AST_DESELECT_QUIET: assert property (
		pins.select_n |=> !twi_enable && sda_oe_n && twi_scl && twi_sda)
		else $error("deselected module touched the bus");
	AST_SELECT_ACTS: assert property (
		(selected && bus_ready_q && state_q != MSC_ST_HOLD)
		|=> twi_enable && (twi_scl == $past(pins.scl)))
		else $error("selected and ready module not enabled");
	AST_PULLUP_ON: assert property (
		select_pullup_en)
		else $error("select pull-up released");
	// a pulse of exactly the least width may rise again at once
	AST_RESET_TAKEN: assert property (
		(state_q == MSC_ST_RUN && !pins.reset_n && rst_cnt_q == RST_LAST)
		|=> state_q == MSC_ST_HOLD && settings_reset &&
		mask_q == MSC_MASK_RESET && control_q == MSC_CONTROL_RESET)
		else $error("long reset pulse did not reset the module");
	AST_SHORT_PULSE_IGNORED: assert property (
		(state_q == MSC_ST_RUN && rst_cnt_q != RST_LAST)
		|=> state_q != MSC_ST_HOLD)
		else $error("reset taken before the least pulse width");
	AST_INIT_ON_RISE: assert property (
		(state_q == MSC_ST_HOLD) |=> ($past(pins.reset_n) ?
		(state_q == MSC_ST_INIT && init_cnt_q == '0) :
		state_q == MSC_ST_HOLD))
		else $error("init window not started by the reset release");
	AST_DONE_IRQ: assert property (
		(state_q == MSC_ST_INIT && init_cnt_q == last_count(INIT_CYCLES) &&
		pins.reset_n) |=> state_q == MSC_ST_RUN && !not_ready_q &&
		status_q[MSC_ST_RESET_DONE] ##1
		(!$past(mask_q[MSC_ST_RESET_DONE]) || !module_interrupt_n_oe_n))
		else $error("reset completion not posted");
	AST_POWERUP_INIT: assert property (
		!$past(rst_n) |-> state_q == MSC_ST_INIT && not_ready_q)
		else $error("power-up did not enter the init window");
	AST_LOW_POWER: assert property (
		pins.low_power |=> low_power_state)
		else $error("low power request not obeyed");
	AST_PRESENT_LOW: assert property (
		!module_present_n)
		else $error("presence pin released");
	AST_IRQ_PIN: assert property (
		(|(status_q & mask_q)) |=> !module_interrupt_n_oe_n)
		else $error("pending unmasked flag not on the interrupt pin");
	AST_INIT_BOUND: assert property (
		state_q == MSC_ST_INIT |-> init_cnt_q <= last_count(INIT_CYCLES))
		else $error("init window ran past its limit");
	AST_BUS_READY: assert property (
		state_q == MSC_ST_RUN |-> bus_ready_q)
		else $error("bus not ready after init");
	AST_FLAG_READ: assert property (
		(reg_re && reg_addr == MSC_ADDR_STATUS && !enter_hold &&
		state_q != MSC_ST_HOLD)
		|=> reg_rdata == $past(status_q) && status_q == $past(status_set))
		else $error("status read lost flags or did not clear them");

endmodule : msc_sideband

// ===== tb/msc_host_model.sv
// host board side of the sideband pins: select, reset, low power, 2-wire
// assumes one clock shared with the bench; pins change after rising edges
module msc_host_model (
	input wire logic clock,
	input wire logic sda_out,
	input wire logic sda_oe_n,
	input wire logic int_out,
	input wire logic int_oe_n,
	input wire logic present_n,
	output logic select_n,
	output logic reset_n,
	output logic low_power,
	output logic scl,
	output logic sda_line,
	output logic int_line_n,
	output logic present_line_n
);
	timeunit 1ns;
	timeprecision 1ps;

	logic host_sda;

	// open-drain data and interrupt lines with host pull-ups; presence follows the module pin directly
	assign sda_line = host_sda & (sda_oe_n | sda_out);
	assign int_line_n = int_oe_n ? 1'b1 : int_out;
	assign present_line_n = present_n;

	initial begin
		select_n = 1'b1;
		reset_n = 1'b1;
		low_power = 1'b0;
		scl = 1'b1;
		host_sda = 1'b1;
	end

	task automatic set_pins(input logic sel, input logic lp, input logic sc);
		@(posedge clock);
		select_n <= sel;
		low_power <= lp;
		scl <= sc;
	endtask : set_pins

	// reset pulse width
	// short pulses are only commanded on purpose, to probe the filter
	task automatic reset_pulse(input int cycles);
		@(posedge clock);
		reset_n <= 1'b0;
		repeat (cycles) @(posedge clock);
		reset_n <= 1'b1;
	endtask : reset_pulse
endmodule : msc_host_model

// ===== tb/tb_top.sv
// self-checking bench for the sideband control block
// assumes a short init count so a reset completes in tens of cycles
module tb_top
	import msc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int INIT = 50;
	logic clock = 1'b0;
	logic rst_n, sel, rstp, lp, scl, sda_line, sda_out, sda_oe_n, pull_en;
	logic twi_en, twi_scl, twi_sda, drv_low, lps, setr, pres_n;
	logic int_out, int_oe_n, int_line_n, pres_line_n, we, re;
	logic [MSC_CHANNELS-1:0] alarm, warn;
	logic [MSC_ADDR_W-1:0] addr;
	logic [MSC_DATA_W-1:0] wdata, rdata;
	int miscompares = 0;
	int n_checks = 0;

	always #10 clock = ~clock;

	msc_sideband #(.INIT_CYCLES(INIT), .SERIAL_CYCLES(INIT)) u_dut (
		.clock(clock), .rst_n(rst_n), .module_select_n_pin(sel),
		.module_reset_n(rstp), .low_power_request(lp), .scl_pin(scl),
		.sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
		.select_pullup_en(pull_en), .twi_enable(twi_en),
		.twi_scl(twi_scl), .twi_sda(twi_sda), .twi_sda_drive_low(drv_low),
		.chan_alarm(alarm), .chan_warn(warn), .low_power_state(lps),
		.settings_reset(setr), .module_present_n(pres_n),
		.module_interrupt_n_out(int_out),
		.module_interrupt_n_oe_n(int_oe_n), .reg_addr(addr),
		.reg_wdata(wdata), .reg_we(we), .reg_re(re), .reg_rdata(rdata)
	);

	msc_host_model u_host (
		.clock(clock), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
		.int_out(int_out), .int_oe_n(int_oe_n), .present_n(pres_n),
		.select_n(sel), .reset_n(rstp), .low_power(lp), .scl(scl),
		.sda_line(sda_line), .int_line_n(int_line_n),
		.present_line_n(pres_line_n)
	);

	task automatic end_sim;
		$display("miscompares=%0d n_checks=%0d", miscompares, n_checks);
		if (miscompares == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : end_sim

	task automatic chk(input logic [15:0] got, input logic [15:0] exp,
			input string msg);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: %s got %h want %h", $time, msg,
				got, exp);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : cyc

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		we <= 1'b1;
		@(posedge clock);
		we <= 1'b0;
	endtask : wr

	// read data stands only in the cycle after the strobe
	task automatic rdchk(input logic [3:0] a, input logic [15:0] exp,
			input string msg);
		@(posedge clock);
		addr <= a;
		re <= 1'b1;
		@(posedge clock);
		re <= 1'b0;
		#1;
		chk(rdata, exp, msg);
	endtask : rdchk

	// bounded wait for the interrupt line, n is cycles spent
	task automatic wait_int(input int lim, output int n);
		n = 0;
		while (int_line_n !== 1'b0 && n < lim) begin
			cyc(1);
			n++;
		end
		// judged on the line itself, so a late but final edge still counts
		if (int_line_n !== 1'b0) begin
			miscompares++;
			$display("unexpected at %0t: no interrupt", $time);
			end_sim;
		end
	endtask : wait_int

	task automatic t_power;
		int n;
		wait_int(INIT + 10, n);
		rdchk(MSC_ADDR_STATE, 16'h0010, "state after power-up");
		rdchk(MSC_ADDR_STATUS, 16'h0001, "reset done");
		cyc(2);
		chk(int_line_n, 16'h0001, "int kept after read");
		rdchk(MSC_ADDR_STATUS, 16'h0000, "status not cleared");
		rdchk(MSC_ADDR_MASK, MSC_MASK_RESET, "mask default");
		rdchk(MSC_ADDR_CONTROL, MSC_CONTROL_RESET, "control default");
		wr(4'hF, 16'hFFFF);
		rdchk(4'hF, 16'h0000, "unmapped read");
		wr(MSC_ADDR_STATE, 16'hFFFF);
		rdchk(MSC_ADDR_STATE, 16'h0010, "state written");
		chk(pres_line_n, 16'h0000, "presence");
		chk(pull_en, 16'h0001, "select pull-up");
	endtask : t_power

	task automatic t_select;
		u_host.set_pins(1'b1, 1'b0, 1'b0);
		drv_low <= 1'b1;
		cyc(6);
		chk(twi_en, 16'h0000, "core enabled unselected");
		chk(twi_scl, 16'h0001, "clock leaked");
		chk(twi_sda, 16'h0001, "data leaked to core");
		chk(sda_line, 16'h0001, "data driven unselected");
		u_host.set_pins(1'b0, 1'b0, 1'b0);
		cyc(6);
		chk(twi_en, 16'h0000 | 16'h0001, "core not enabled");
		chk(twi_scl, 16'h0000, "clock not passed");
		chk(sda_line, 16'h0000, "data not driven");
		// line low after 3 cycles, back through the sync after 3 more
		chk(twi_sda, 16'h0000, "data not passed to core");
		rdchk(MSC_ADDR_STATE, 16'h0012, "state selected");
		@(posedge clock);
		drv_low <= 1'b0;
	endtask : t_select

	task automatic t_flags;
		wr(MSC_ADDR_MASK, 16'h0000);
		@(posedge clock);
		alarm <= 4'h4;
		warn <= 4'h2;
		@(posedge clock);
		alarm <= 4'h0;
		warn <= 4'h0;
		cyc(3);
		chk(int_line_n, 16'h0001, "masked event raised int");
		wr(MSC_ADDR_MASK, 16'h01FF);
		cyc(2);
		chk(int_line_n, 16'h0000, "event not flagged");
		rdchk(MSC_ADDR_STATUS, 16'h0048, "flags");
		cyc(2);
		chk(int_line_n, 16'h0001, "int stuck");
	endtask : t_flags

	task automatic t_lowpow;
		u_host.set_pins(1'b0, 1'b1, 1'b0);
		cyc(5);
		chk(lps, 16'h0001, "low power pin");
		rdchk(MSC_ADDR_STATE, 16'h0016, "state low power");
		u_host.set_pins(1'b0, 1'b0, 1'b0);
		cyc(5);
		chk(lps, 16'h0000, "low power stuck");
		wr(MSC_ADDR_CONTROL, 16'h0001);
		cyc(3);
		chk(lps, 16'h0001, "forced low power");
	endtask : t_lowpow

	task automatic t_reset;
		int n;
		wr(MSC_ADDR_MASK, 16'h0000);
		u_host.reset_pulse(40);
		cyc(10);
		chk(setr, 16'h0000, "short pulse taken");
		rdchk(MSC_ADDR_MASK, 16'h0000, "short pulse reset mask");
		u_host.reset_pulse(120);
		#1;
		chk(setr, 16'h0001, "long pulse ignored");
		wait_int(INIT + 12, n);
		chk(16'(n >= INIT), 16'h0001, "init from falling edge");
		rdchk(MSC_ADDR_STATE, 16'h0012, "not ready after reset");
		rdchk(MSC_ADDR_STATUS, 16'h0001, "reset done");
		rdchk(MSC_ADDR_MASK, MSC_MASK_RESET, "mask kept");
		rdchk(MSC_ADDR_CONTROL, MSC_CONTROL_RESET, "control kept");
		chk(lps, 16'h0000, "low power kept");
	endtask : t_reset

	initial begin
		rst_n = 1'b0;
		drv_low = 1'b0;
		alarm = '0;
		warn = '0;
		addr = '0;
		wdata = '0;
		we = 1'b0;
		re = 1'b0;
		repeat (4) @(posedge clock);
		rst_n <= 1'b1;
		t_power;
		t_select;
		t_flags;
		t_lowpow;
		t_reset;
		end_sim;
	end
endmodule : tb_top
